// >>> hw/ccek_map.svh
// Register offsets, control field positions, reset values and generator
// constants of the checksum engine. Definitions only.
`ifndef CCEK_MAP_SVH
`define CCEK_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CCEK_OFS_CTRL 8'h00
`define CCEK_OFS_FEED 8'h04
`define CCEK_OFS_RSLT 8'h08
`define CCEK_OFS_SEED 8'h0c
`define CCEK_OFS_SADR 8'h10
`define CCEK_OFS_EADR 8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CCEK_B_RUN 0
`define CCEK_B_ORDER 1
`define CCEK_B_AINC 2
`define CCEK_B_GEN_LO 3
`define CCEK_B_GEN_HI 4
`define CCEK_B_ALGO 5
`define CCEK_B_INIT 6
`define CCEK_B_MODE 7
`define CCEK_B_INV 10
`define CCEK_B_WID_LO 14
`define CCEK_B_WID_HI 15
`define CCEK_CTRL_WMASK 32'h0000c4be

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCEK_RST_CTRL 32'h00000000
`define CCEK_RST_FEED 32'h00000000
`define CCEK_RST_RSLT 32'hffffffff
`define CCEK_RST_SEED 32'h00000000
`define CCEK_RST_SADR 32'h10000000
`define CCEK_RST_EADR 32'h10007ffc

// ----------------------------------------
// Generators: top aligned for msb first, reflected for lsb first
// ----------------------------------------
`define CCEK_TP_CCITT 32'h10210000
`define CCEK_TP_CRC16 32'h80050000
`define CCEK_TP_CRC8 32'h07000000
`define CCEK_TP_CRC32 32'h04c11db7
`define CCEK_RP_CCITT 32'h00008408
`define CCEK_RP_CRC16 32'h0000a001
`define CCEK_RP_CRC8 32'h000000e0
`define CCEK_RP_CRC32 32'hedb88320

`endif

// >>> hw/ccek_pkg.sv
// Types shared by the checksum engine files.
// Assumes the constants header is included where offsets are needed.
package ccek_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {CCEK_W32, CCEK_W16, CCEK_W8, CCEK_WRSV} ccek_width_t;
   typedef enum logic [1:0] {CCEK_G_CCITT, CCEK_G_CRC16, CCEK_G_CRC8, CCEK_G_CRC32} ccek_gen_t;
   typedef enum {CCEK_ST_IDLE, CCEK_ST_USER, CCEK_ST_AUTO} ccek_state_t;

endpackage

// >>> hw/ccek_step_if.sv
// Bundle between the engine control and its one-step calculator.
// Assumes both ends sit on the same clock; the step is combinational.
`timescale 1ns/10ps
interface ccek_step_if;
   logic [31:0] acc;
   logic [31:0] unit;
   ccek_pkg::ccek_width_t width;
   ccek_pkg::ccek_gen_t gen;
   logic lsb_first;
   logic algo_sum;
   logic [31:0] nxt;

   modport eng (output acc, unit, width, gen, lsb_first, algo_sum, input nxt);
   modport calc (input acc, unit, width, gen, lsb_first, algo_sum, output nxt);
endinterface

// >>> hw/ccek_step.sv
// One calculation step: CRC over one input unit, or checksum add.
// Assumes the unit is already lane selected, inverted and zero extended.
`timescale 1ns/10ps
`include "ccek_map.svh"
module ccek_step (
   // Step bundle
   ccek_step_if.calc s
);

   // ----------------------------------------
   // Bit count of one unit
   // ----------------------------------------
   function automatic logic [5:0] unit_bits(input ccek_pkg::ccek_width_t w);
      case (w)
         ccek_pkg::CCEK_W32: unit_bits = 6'd32;
         ccek_pkg::CCEK_W16: unit_bits = 6'd16;
         default: unit_bits = 6'd8;
      endcase
   endfunction

   logic [5:0] nb;
   logic [5:0] cw;
   logic [5:0] sh;
   logic [31:0] tpoly;
   logic [31:0] rpoly;
   logic [31:0] c;
   logic [31:0] u;
   logic fb;

   assign nb = unit_bits(s.width);

   // ----------------------------------------
   // Generator tables
   // ----------------------------------------
   always_comb begin
      case (s.gen)
         ccek_pkg::CCEK_G_CCITT: begin
            cw = 6'd16;
            tpoly = `CCEK_TP_CCITT;
            rpoly = `CCEK_RP_CCITT;
         end
         ccek_pkg::CCEK_G_CRC16: begin
            cw = 6'd16;
            tpoly = `CCEK_TP_CRC16;
            rpoly = `CCEK_RP_CRC16;
         end
         ccek_pkg::CCEK_G_CRC8: begin
            cw = 6'd8;
            tpoly = `CCEK_TP_CRC8;
            rpoly = `CCEK_RP_CRC8;
         end
         default: begin
            cw = 6'd32;
            tpoly = `CCEK_TP_CRC32;
            rpoly = `CCEK_RP_CRC32;
         end
      endcase
   end

   assign sh = 6'd32 - cw;

   // ----------------------------------------
   // Serial division, unrolled over the unit
   // ----------------------------------------
   always_comb begin
      fb = 1'b0;
      u = s.unit;
      c = (s.acc << sh) >> sh;
      if (s.algo_sum) begin
         c = s.acc + s.unit;
      end else if (s.lsb_first) begin
         for (int i = 0; i < 32; i++) begin
            if (6'(i) < nb) begin
               fb = c[0] ^ u[0];
               c = (c >> 1) ^ (fb ? rpoly : 32'h00000000);
               u = u >> 1;
            end
         end
      end else begin
         c = c << sh;
         u = u << (6'd32 - nb);
         for (int i = 0; i < 32; i++) begin
            if (6'(i) < nb) begin
               fb = c[31] ^ u[31];
               c = (c << 1) ^ (fb ? tpoly : 32'h00000000);
               u = u << 1;
            end
         end
         c = c >> sh;
      end
      s.nxt = c;
   end

endmodule // ccek_step

// >>> hw/ccek_top.sv
// CRC and checksum engine with a classic Wishbone register slave.
// Assumes flash answers on the same clock with a one-cycle ack pulse.
`timescale 1ns/10ps
`include "ccek_map.svh"
module ccek_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Wishbone slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Flash read port
   output logic flash_req_o,
   output logic [31:0] flash_addr_o,
   input wire logic [31:0] flash_rdata_i,
   input wire logic flash_ack_i,
   // Processor hold
   output logic cpu_stall_o
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] sel);
      merge = o;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merge[b*8 +: 8] = n[b*8 +: 8];
         end
      end
   endfunction

   function automatic logic [31:0] lane(input logic [31:0] w, input logic [1:0] a,
                                        input ccek_pkg::ccek_width_t wd);
      case (wd)
         ccek_pkg::CCEK_W32: lane = w;
         ccek_pkg::CCEK_W16: lane = a[1] ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
         default: lane = {24'h000000, w[a*8 +: 8]};
      endcase
   endfunction

   function automatic logic [31:0] prep(input logic [31:0] r, input logic inv,
                                        input ccek_pkg::ccek_width_t wd);
      logic [31:0] v;
      v = inv ? ~r : r;
      case (wd)
         ccek_pkg::CCEK_W32: prep = v;
         ccek_pkg::CCEK_W16: prep = {16'h0000, v[15:0]};
         default: prep = {24'h000000, v[7:0]};
      endcase
   endfunction

   function automatic logic [31:0] unit_size(input ccek_pkg::ccek_width_t wd);
      case (wd)
         ccek_pkg::CCEK_W32: unit_size = 32'd4;
         ccek_pkg::CCEK_W16: unit_size = 32'd2;
         default: unit_size = 32'd1;
      endcase
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   ccek_pkg::ccek_state_t state_q;
   ccek_pkg::ccek_state_t state_d;
   logic [31:0] ctrl_q;
   logic [31:0] feed_q;
   logic [31:0] rslt_q;
   logic [31:0] rslt_d;
   logic [31:0] seed_q;
   logic [31:0] sadr_q;
   logic [31:0] sadr_d;
   logic [31:0] eadr_q;
   logic ack_q;
   logic [31:0] dat_q;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire [7:0] wadr = {wb_adr_i[7:2], 2'b00};
   wire wr = wb_req & wb_we_i;
   wire auto_run = (state_q == ccek_pkg::CCEK_ST_AUTO);
   wire user_run = (state_q == ccek_pkg::CCEK_ST_USER);
   wire run_w = auto_run | user_run;
   wire [31:0] ctrl_rd = ctrl_q | {31'h00000000, run_w};
   wire we_ctrl = wr & (wadr == `CCEK_OFS_CTRL);
   wire we_feed = wr & (wadr == `CCEK_OFS_FEED);
   wire we_seed = wr & (wadr == `CCEK_OFS_SEED);
   wire we_sadr = wr & (wadr == `CCEK_OFS_SADR);
   wire we_eadr = wr & (wadr == `CCEK_OFS_EADR);
   wire ctrl_wr = we_ctrl & ~auto_run;
   wire [31:0] wctrl = merge(ctrl_rd, wb_dat_i, wb_sel_i);
   wire [31:0] wfeed = merge(feed_q, wb_dat_i, wb_sel_i);

   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   wire ccek_pkg::ccek_width_t width =
      ccek_pkg::ccek_width_t'(ctrl_q[`CCEK_B_WID_HI:`CCEK_B_WID_LO]);
   wire ccek_pkg::ccek_gen_t gen =
      ccek_pkg::ccek_gen_t'(ctrl_q[`CCEK_B_GEN_HI:`CCEK_B_GEN_LO]);
   wire inv = ctrl_q[`CCEK_B_INV];
   wire algo = ctrl_q[`CCEK_B_ALGO];
   wire ainc = ctrl_q[`CCEK_B_AINC];
   wire lsb = ctrl_q[`CCEK_B_ORDER];

   // ----------------------------------------
   // Step control
   // ----------------------------------------
   // Feed writes outside a run are stored but never calculated
   wire feed_step = we_feed & user_run;
   wire auto_step = auto_run & flash_ack_i;
   wire step_fire = feed_step | auto_step;
   wire at_end = (sadr_q == eadr_q);
   wire adv = auto_step | (feed_step & ainc);
   wire finish = adv & at_end;
   wire [31:0] raw = auto_run ? lane(flash_rdata_i, sadr_q[1:0], width) : wfeed;

   ccek_step_if sif ();

   assign sif.acc = rslt_q;
   assign sif.unit = prep(raw, inv, width);
   assign sif.width = width;
   assign sif.gen = gen;
   assign sif.lsb_first = lsb;
   assign sif.algo_sum = algo;

   ccek_step u_step (
      .s(sif.calc)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      if (ctrl_wr) begin
         if (!wctrl[`CCEK_B_RUN]) begin
            state_d = ccek_pkg::CCEK_ST_IDLE;
         end else if (wctrl[`CCEK_B_MODE]) begin
            state_d = ccek_pkg::CCEK_ST_AUTO;
         end else begin
            state_d = ccek_pkg::CCEK_ST_USER;
         end
      end else if (finish) begin
         state_d = ccek_pkg::CCEK_ST_IDLE;
      end
   end

   // The pointer stops on the end address, so both read equal after a run that reaches it
   assign sadr_d = (adv & ~at_end) ? sadr_q + unit_size(width) :
                   (we_sadr & ~auto_run) ? merge(sadr_q, wb_dat_i, wb_sel_i) : sadr_q;

   assign rslt_d = (ctrl_wr & wctrl[`CCEK_B_INIT]) ? seed_q :
                   step_fire ? sif.nxt : rslt_q;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= ccek_pkg::CCEK_ST_IDLE;
         ctrl_q <= `CCEK_RST_CTRL;
         rslt_q <= `CCEK_RST_RSLT;
         sadr_q <= `CCEK_RST_SADR;
      end else begin
         state_q <= state_d;
         rslt_q <= rslt_d;
         sadr_q <= sadr_d;
         if (ctrl_wr) begin
            ctrl_q <= wctrl & `CCEK_CTRL_WMASK;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         feed_q <= `CCEK_RST_FEED;
         seed_q <= `CCEK_RST_SEED;
         eadr_q <= `CCEK_RST_EADR;
      end else begin
         if (we_feed) begin
            feed_q <= wfeed;
         end
         if (we_seed) begin
            seed_q <= merge(seed_q, wb_dat_i, wb_sel_i);
         end
         if (we_eadr & ~auto_run) begin
            eadr_q <= merge(eadr_q, wb_dat_i, wb_sel_i);
         end
      end
   end

   // ----------------------------------------
   // Read data and acknowledge
   // ----------------------------------------
   logic [31:0] rd_w;
   always_comb begin
      case (wadr)
         `CCEK_OFS_CTRL: rd_w = ctrl_rd;
         `CCEK_OFS_FEED: rd_w = feed_q;
         `CCEK_OFS_RSLT: rd_w = auto_run ? 32'h00000000 : rslt_q;
         `CCEK_OFS_SEED: rd_w = seed_q;
         `CCEK_OFS_SADR: rd_w = sadr_q;
         `CCEK_OFS_EADR: rd_w = eadr_q;
         default: rd_w = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= wb_req;
         if (wb_req & ~wb_we_i) begin
            dat_q <= rd_w;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign flash_req_o = auto_run;
   assign flash_addr_o = {sadr_q[31:2], 2'b00};
   // Held for the whole auto run; flash is busy with the scan
   assign cpu_stall_o = auto_run;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   sequence s_auto_start;
      ctrl_wr && wctrl[`CCEK_B_RUN] && wctrl[`CCEK_B_MODE];
   endsequence

   a_wb_ack_pulse: assert property (wb_req |=> s_ack_pulse)
      else $error("ack not a single pulse");
   a_stall_auto: assert property (s_auto_start |=> cpu_stall_o && flash_req_o)
      else $error("auto start did not stall");
   a_done_ptrs: assert property (finish |=> sadr_q == eadr_q && !ctrl_rd[0])
      else $error("run ended with pointers apart");
   a_ctrl_locked: assert property (we_ctrl && auto_run |=> $stable(ctrl_q))
      else $error("control changed in auto run");
   a_rslt_hidden: assert property (wb_req && !wb_we_i && wadr == `CCEK_OFS_RSLT
      && auto_run |=> wb_ack_o && wb_dat_o == 32'h00000000)
      else $error("result visible in auto run");
   a_init_load: assert property (ctrl_wr && wctrl[`CCEK_B_INIT] |=>
      rslt_q == $past(seed_q) && !ctrl_rd[`CCEK_B_INIT])
      else $error("init did not load seed");
   a_sum_wrap: assert property (feed_step && algo && width == ccek_pkg::CCEK_W32
      && !inv && wb_sel_i == 4'hf |=> rslt_q == $past(rslt_q) + $past(wb_dat_i))
      else $error("32-bit checksum wrong");
   a_sum_inv8: assert property (feed_step && algo && width == ccek_pkg::CCEK_W8
      && inv && wb_sel_i[0] |=>
      rslt_q == $past(rslt_q) + {24'h000000, ~$past(wb_dat_i[7:0])})
      else $error("inverted byte checksum wrong");
   a_auto_adv: assert property (auto_step && !at_end && width == ccek_pkg::CCEK_W32
      |=> sadr_q == $past(sadr_q) + 32'd4)
      else $error("auto pointer did not advance");
   a_user_noinc: assert property (feed_step && !ainc |=> $stable(sadr_q))
      else $error("pointer moved without increment");
   a_crc8_msb: assert property (feed_step && !algo && gen == ccek_pkg::CCEK_G_CRC8
      && !lsb && !inv && width == ccek_pkg::CCEK_W8 && rslt_q == 32'h00000000
      && wb_sel_i[0] && wb_dat_i[7:0] == 8'h01 |=> rslt_q == 32'h00000007)
      else $error("crc8 msb step wrong");

endmodule // ccek_top

// >>> test/ccek_flash_model.sv
// Behavioural flash that answers the engine's word reads.
// Assumes the engine's clock; one ack pulse per word, optionally slow.
`timescale 1ns/10ps
module ccek_flash_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Read port
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic slow_i,
   output logic [31:0] rdata_o,
   output logic ack_o
);
   // ----------------------------------------
   // Answer logic
   // ----------------------------------------
   logic [1:0] wait_q;
   logic in_flash;
   logic go;
   // Only the flash window answers; anything else would hang the run
   assign in_flash = addr_i[31:15] == 17'h02000;
   assign go = req_i && !ack_o && in_flash && (wait_q == 2'h3 || !slow_i);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 2'h0;
         ack_o <= 1'b0;
         rdata_o <= 32'h0;
      end else begin
         ack_o <= go;
         wait_q <= (req_i && !go) ? wait_q + 2'h1 : 2'h0;
         // Data outside an ack is scrambled so a stale sample shows up
         rdata_o <= go ? addr_i * 32'h3 : ~rdata_o;
      end
   end
endmodule // ccek_flash_model

// >>> test/testbench.sv
// Self-checking bench for the checksum engine over Wishbone.
// Assumes ccek_top and the flash model; 100 MHz clock.
`timescale 1ns/10ps
module testbench;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic slow = 1'b0;
   logic [3:0] sel = 4'h0;
   logic [31:0] rdat, fdat, faddr, q, sum;
   logic ack, freq, fack, stall;
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   logic [31:0] exp_crc [2][4] = '{'{32'h1021, 32'h8005, 32'h07, 32'h04c11db7},
      '{32'h8408, 32'ha001, 32'he0, 32'hedb88320}};
   logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'hffffffff, 32'h0, 32'h10000000,
      32'h10007ffc, 32'h0};

   always #5 sys_clk_i = ~sys_clk_i;

   ccek_top u_ccek_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(rdat), .wb_ack_o(ack), .flash_req_o(freq), .flash_addr_o(faddr),
      .flash_rdata_i(fdat), .flash_ack_i(fack), .cpu_stall_o(stall));
   ccek_flash_model u_ccek_flash_model (.clk_i(sys_clk_i), .rst_i(sys_rst_i),
      .req_i(freq), .addr_i(faddr), .slow_i(slow), .rdata_o(fdat), .ack_o(fack));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      cmp_count++;
      if (seen !== ex) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, ex, seen);
      end
   endtask

   // Classic cycle: hold until ack is sampled, then release for a cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] m = 4'hf);
      @(posedge sys_clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= m;
      do @(posedge sys_clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
   endtask

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      wb(1, 8'h08, 32'h12345678);
      for (int i = 0; i < 7; i++) begin
         wb(0, 8'(i * 4), 32'h0);
         chk("reset value", q, rst_val[i]);
      end
      // Every generator in both shift orders, one 8-bit unit from zero seed
      for (int o = 0; o < 2; o++) begin
         for (int g = 0; g < 4; g++) begin
            wb(1, 8'h00, 32'h00008041 | 32'(g << 3) | 32'(o << 1));
            wb(1, 8'h04, o ? 32'h80 : 32'h01);
            wb(0, 8'h08, 32'h0);
            chk("crc", q, exp_crc[o][g]);
         end
      end
      wb(1, 8'h00, 32'h00008461);
      wb(0, 8'h00, 32'h0);
      chk("ctrl", q, 32'h00008421);
      wb(1, 8'h04, 32'h00000012);
      wb(1, 8'h04, 32'habcdff00);
      wb(0, 8'h08, 32'h0);
      chk("sum inv", q, 32'h000001ec);
      wb(1, 8'h00, 32'h0);
      wb(1, 8'h04, 32'h1);
      wb(0, 8'h08, 32'h0);
      chk("stopped", q, 32'h000001ec);
      wb(1, 8'h0c, 32'hffffffff);
      wb(1, 8'h00, 32'h00000061);
      wb(1, 8'h04, 32'h2);
      wb(0, 8'h08, 32'h0);
      chk("wrap", q, 32'h1);
      // One byte lane of the seed, then init copies the merged seed
      wb(1, 8'h0c, 32'h00001200, 4'h2);
      wb(1, 8'h00, 32'h00000041);
      wb(0, 8'h08, 32'h0);
      chk("seed lane", q, 32'hffff12ff);
      // Software keeps end above start
      wb(1, 8'h0c, 32'h0);
      wb(1, 8'h10, 32'h100);
      wb(1, 8'h14, 32'h104);
      wb(1, 8'h00, 32'h00000065);
      wb(1, 8'h04, 32'h1);
      wb(1, 8'h04, 32'h2);
      wb(0, 8'h10, 32'h0);
      chk("autoinc start", q, 32'h104);
      wb(0, 8'h00, 32'h0);
      chk("autoinc done", q, 32'h24);
      wb(0, 8'h08, 32'h0);
      chk("autoinc sum", q, 32'h3);
      // Halfword units: pointer steps by two, sum keeps the carry
      wb(1, 8'h14, 32'h102);
      wb(1, 8'h10, 32'h100);
      wb(1, 8'h00, 32'h00004065);
      wb(1, 8'h04, 32'h12345678);
      wb(1, 8'h04, 32'h0000ffff);
      wb(0, 8'h10, 32'h0);
      chk("half start", q, 32'h102);
      wb(0, 8'h08, 32'h0);
      chk("half sum", q, 32'h00015677);
      // Auto runs, slow flash then prompt flash, over a 0x7c span
      for (int s = 1; s >= 0; s--) begin
         // Slow answers stand in for flash wait states at a low bus clock
         slow <= s[0];
         wb(1, 8'h10, 32'h10000000);
         wb(1, 8'h14, 32'h1000007c);
         wb(1, 8'h00, 32'h000000e1);
         chk("stall", {31'h0, stall}, 32'h1);
         wb(1, 8'h00, 32'h0);
         wb(1, 8'h10, 32'h0);
         wb(0, 8'h08, 32'h0);
         chk("hidden result", q, 32'h0);
         n = 0;
         while (freq === 1'b1 && n < 2000) begin
            @(posedge sys_clk_i);
            n++;
         end
         @(posedge sys_clk_i);
         chk("stall off", {31'h0, stall}, 32'h0);
         chk("run ended", {31'h0, freq}, 32'h0);
         sum = 32'h0;
         for (int i = 0; i < 32; i++) sum += (32'h10000000 + 32'(i * 4)) * 32'h3;
         wb(0, 8'h08, 32'h0);
         chk("auto sum", q, sum);
         wb(0, 8'h10, 32'h0);
         chk("auto start", q, 32'h1000007c);
         wb(0, 8'h00, 32'h0);
         chk("auto ctrl", q, 32'ha0);
      end
      // Only reset or reaching the end address stops an auto run; control is locked while it runs
      wb(1, 8'h10, 32'h10000000);
      wb(1, 8'h00, 32'h000000e1);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk("reset stall", {31'h0, stall}, 32'h0);
      wb(0, 8'h00, 32'h0);
      chk("reset ctrl", q, 32'h0);
      results();
   end
endmodule // testbench
